// File: verilog/rpm_pkg.sv
// Purpose: shared constants and types for the receiver power-mode control
// Assumes: system clock at 100 MHz
// Notes: all clk_sys timing counts are derived from times given in nanoseconds
`default_nettype none
package rpm_pkg;
  localparam int CLK_SYS_MHZ = 100;
  // enable glitch filter, shortest accepted pulse
  localparam int GLITCH_NS = 3800;
  localparam int GLITCH_CYC = (GLITCH_NS * CLK_SYS_MHZ) / 1000;
  // disable and standby bounds, for reference only; no count below uses them
  localparam int PWRDN_MAX_NS = 11000;
  localparam int STANDBY_MAX_NS = 3000;
  // link counts as stopped after this long without a toggle
  localparam int LINK_IDLE_NS = 1000;
  localparam int LINK_IDLE_CYC = (LINK_IDLE_NS * CLK_SYS_MHZ) / 1000;
  // modelled pll lock time, well inside the 2 ms wake bound
  localparam int WAKE_MAX_NS = 2000000;
  localparam int PLL_LOCK_NS = 1000000;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_NS / 1000) * CLK_SYS_MHZ;
  localparam int LOCK_CNT_W = 20;
  localparam int IDLE_CNT_W = 8;
  localparam int GLITCH_CNT_W = 9;
  // pixel clock delay in link clock periods
  localparam int PCLK_DELAY = 2;
  // word layout {pixel[23:0], vsync, hsync, data enable}
  localparam int WORD_W = 27;
  localparam int PIX_W = 24;
  localparam int VS_BIT = 2;
  localparam int HS_BIT = 1;
  localparam int DE_BIT = 0;
  // static levels while disabled
  localparam logic [PIX_W-1:0] PIX_IDLE = 24'hFFFFFF;
  localparam logic SYNC_IDLE = 1'h1;
  localparam logic DE_IDLE = 1'h0;
  localparam logic PCLK_IDLE = 1'h0;
  typedef enum logic [1:0] {
    ST_SHUTDOWN = 2'b00,
    ST_STANDBY = 2'b01,
    ST_ACQUIRE = 2'b10,
    ST_ACTIVE = 2'b11
  } rpm_state_e;
endpackage
`default_nettype wire

// File: verilog/rpm_link_if.sv
// Purpose: carries link-clock-domain signals to the power controller core
// Assumes: both signals are produced on the link clock
// Notes: the toggle is an event marker, crossed by the core
`timescale 1ns/1ps
`default_nettype none
interface rpm_link_if;
  logic linkToggle;
  logic pixelClk;
  modport gen
  (
    output linkToggle,
    output pixelClk
  );
  modport core
  (
    input linkToggle,
    input pixelClk
  );
endinterface
`default_nettype wire

// File: verilog/rpm_glitch_filter.sv
// Purpose: filters the receive-enable pin against short excursions
// Assumes: raw input is asynchronous to clk_sys
// Notes: a level must persist GLITCH_CYC cycles before it is accepted
`timescale 1ns/1ps
`default_nettype none
module rpm_glitch_filter
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic rawIn,
  output logic filtOut
);
  logic [1:0] sync_reg;
  logic filt_reg;
  logic [rpm_pkg::GLITCH_CNT_W-1:0] cnt_reg;
  logic [rpm_pkg::GLITCH_CNT_W-1:0] cnt_next;
  wire differs = sync_reg[1] ^ filt_reg;
  wire accept = differs &&
    (cnt_reg == rpm_pkg::GLITCH_CNT_W'(rpm_pkg::GLITCH_CYC - 1));
  ////////////////////////////////////////////////////////////////////////
  // same counter for both directions, so rises and falls filter alike
  assign cnt_next = differs ? cnt_reg + 1'b1 : '0;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync_reg <= 2'h0;
      filt_reg <= 1'h0;
      cnt_reg <= '0;
    end
    else
    begin
      sync_reg <= {sync_reg[0], rawIn};
      cnt_reg <= accept ? '0 : cnt_next;
      if (accept)
      begin
        filt_reg <= sync_reg[1];
      end
    end
  end
  assign filtOut = filt_reg;
endmodule
`default_nettype wire

// File: verilog/rpm_pclk_gen.sv
// Purpose: recreates the pixel clock two link periods after the link edge
// Assumes: link clock may stop; nothing here must finish after it stops
// Notes: built from rise and fall flops so no clock is sampled as data
`timescale 1ns/1ps
`default_nettype none
module rpm_pclk_gen
(
  input wire logic clk_link,
  input wire logic rstLink_b,
  input wire logic polarityIn,
  rpm_link_if.gen linkIf
);
  localparam int D = rpm_pkg::PCLK_DELAY;
  logic [D:0] riseTog_reg;
  logic [D:0] fallTog_reg;
  logic [1:0] polSync_reg;
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_link or negedge rstLink_b)
  begin
    if (!rstLink_b)
    begin
      riseTog_reg <= '0;
      polSync_reg <= 2'h0;
    end
    else
    begin
      riseTog_reg <= {riseTog_reg[D-1:0], ~riseTog_reg[0]};
      polSync_reg <= {polSync_reg[0], polarityIn};
    end
  end
  // fall stage 0 samples the rise toggle half a period late
  always_ff @(negedge clk_link or negedge rstLink_b)
  begin
    if (!rstLink_b)
    begin
      fallTog_reg <= '0;
    end
    else
    begin
      fallTog_reg <= {fallTog_reg[D-1:0], riseTog_reg[0]};
    end
  end
  // high from rise D to fall D: the link clock shifted by D periods
  assign linkIf.pixelClk = (riseTog_reg[D] ^ fallTog_reg[D]) ^
    polSync_reg[1];
  assign linkIf.linkToggle = riseTog_reg[0];
endmodule
`default_nettype wire

// File: verilog/rpm_receiver_power_mode_control.sv
// Purpose: power-mode sequencer of a serial-to-parallel video receiver
// Assumes: clk_sys 100 MHz; clk_link from the transmitter, may stop
// Notes: pll lock is modelled by a timer; datapath arrives as whole words
`timescale 1ns/1ps
`default_nettype none
module rpm_receiver_power_mode_control
#(
  parameter int LOCK_CYCLES = rpm_pkg::PLL_LOCK_CYC
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_link,
  input wire logic receive_enable_in,
  input wire logic clock_polarity_select,
  input wire logic [rpm_pkg::WORD_W-1:0] linkWordIn,
  input wire logic linkWordValid,
  output logic [rpm_pkg::PIX_W-1:0] pixelOut,
  output logic vertical_sync_out,
  output logic horizontal_sync_out,
  output logic data_enable_out,
  output logic pixelClkOut,
  output logic pllRun,
  output logic pllStandby,
  output logic [1:0] powerState
);
  rpm_link_if linkIf();
  rpm_pkg::rpm_state_e state_reg;
  rpm_pkg::rpm_state_e state_next;
  logic enFilt;
  logic [1:0] rstLinkSync_reg;
  logic rstLink_b;
  logic [rpm_pkg::WORD_W-1:0] linkWord_reg;
  logic [1:0] togSync_reg;
  logic togLast_reg;
  logic [rpm_pkg::IDLE_CNT_W-1:0] idleCnt_reg;
  logic [rpm_pkg::IDLE_CNT_W-1:0] idleCnt_next;
  logic [rpm_pkg::LOCK_CNT_W-1:0] lockCnt_reg;
  logic [rpm_pkg::LOCK_CNT_W-1:0] lockCnt_next;
  logic outEnable_reg;
  logic [1:0] outOnSync_reg;
  logic [rpm_pkg::PIX_W-1:0] pixel_reg;
  logic vsync_reg;
  logic hsync_reg;
  logic de_reg;

  ////////////////////////////////////////////////////////////////////////
  // enable filter
  rpm_glitch_filter uFilter
  (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .rawIn(receive_enable_in),
    .filtOut(enFilt)
  );

  ////////////////////////////////////////////////////////////////////////
  // link domain: reset release synchronised to the link clock
  always_ff @(posedge clk_link or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstLinkSync_reg <= 2'h0;
    end
    else
    begin
      rstLinkSync_reg <= {rstLinkSync_reg[0], 1'h1};
    end
  end
  assign rstLink_b = rstLinkSync_reg[1];

  rpm_pclk_gen uPclk
  (
    .clk_link(clk_link),
    .rstLink_b(rstLink_b),
    .polarityIn(clock_polarity_select),
    .linkIf(linkIf)
  );

  // word register on the link clock; the static override sits after it
  always_ff @(posedge clk_link or negedge rstLink_b)
  begin
    if (!rstLink_b)
    begin
      linkWord_reg <= '0;
    end
    else if (linkWordValid)
    begin
      linkWord_reg <= linkWordIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link activity: toggle crossed by two flops, then edge compared
  wire togChanged = togSync_reg[1] ^ togLast_reg;
  wire idleFull =
    (idleCnt_reg == rpm_pkg::IDLE_CNT_W'(rpm_pkg::LINK_IDLE_CYC));
  wire linkActive = !idleFull;
  assign idleCnt_next = togChanged ? '0 :
    (idleFull ? idleCnt_reg : idleCnt_reg + 1'b1);

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      togSync_reg <= 2'h0;
      togLast_reg <= 1'h0;
      idleCnt_reg <= rpm_pkg::IDLE_CNT_W'(rpm_pkg::LINK_IDLE_CYC);
    end
    else
    begin
      togSync_reg <= {togSync_reg[0], linkIf.linkToggle};
      togLast_reg <= togSync_reg[1];
      idleCnt_reg <= idleCnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power state machine
  wire lockDone =
    (lockCnt_reg == rpm_pkg::LOCK_CNT_W'(LOCK_CYCLES - 1));
  assign lockCnt_next = (state_reg == rpm_pkg::ST_ACQUIRE) ?
    lockCnt_reg + 1'b1 : '0;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      rpm_pkg::ST_SHUTDOWN:
      begin
        if (enFilt)
        begin
          state_next = linkActive ? rpm_pkg::ST_ACQUIRE :
            rpm_pkg::ST_STANDBY;
        end
      end
      rpm_pkg::ST_STANDBY:
      begin
        if (!enFilt)
        begin
          state_next = rpm_pkg::ST_SHUTDOWN;
        end
        else if (linkActive)
        begin
          state_next = rpm_pkg::ST_ACQUIRE;
        end
      end
      rpm_pkg::ST_ACQUIRE:
      begin
        if (!enFilt)
        begin
          state_next = rpm_pkg::ST_SHUTDOWN;
        end
        else if (!linkActive)
        begin
          state_next = rpm_pkg::ST_STANDBY;
        end
        else if (lockDone)
        begin
          state_next = rpm_pkg::ST_ACTIVE;
        end
      end
      rpm_pkg::ST_ACTIVE:
      begin
        if (!enFilt)
        begin
          state_next = rpm_pkg::ST_SHUTDOWN;
        end
        else if (!linkActive)
        begin
          state_next = rpm_pkg::ST_STANDBY;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= rpm_pkg::ST_SHUTDOWN;
      lockCnt_reg <= '0;
      outEnable_reg <= 1'h0;
    end
    else
    begin
      state_reg <= state_next;
      lockCnt_reg <= lockCnt_next;
      // outputs open only once the lock timer has run out
      outEnable_reg <= (state_next == rpm_pkg::ST_ACTIVE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs; the override is asynchronous to the link clock on purpose,
  // since the link clock may already have stopped when it is needed
  wire [rpm_pkg::PIX_W-1:0] wordPixel =
    linkWord_reg[rpm_pkg::WORD_W-1:rpm_pkg::WORD_W-rpm_pkg::PIX_W];
  wire outOnLink = outOnSync_reg[1];

  // enable crossed into the link domain; clearing needs no link clock
  always_ff @(posedge clk_link or negedge outEnable_reg)
  begin
    if (!outEnable_reg)
    begin
      outOnSync_reg <= 2'h0;
    end
    else
    begin
      outOnSync_reg <= {outOnSync_reg[0], 1'h1};
    end
  end

  // static at once on disable; loading waits for the crossed enable,
  // so an asynchronous release never meets a changing data input
  always_ff @(posedge clk_link or negedge outEnable_reg)
  begin
    if (!outEnable_reg)
    begin
      pixel_reg <= rpm_pkg::PIX_IDLE;
      vsync_reg <= rpm_pkg::SYNC_IDLE;
      hsync_reg <= rpm_pkg::SYNC_IDLE;
      de_reg <= rpm_pkg::DE_IDLE;
    end
    else if (outOnLink)
    begin
      pixel_reg <= wordPixel;
      vsync_reg <= linkWord_reg[rpm_pkg::VS_BIT];
      hsync_reg <= linkWord_reg[rpm_pkg::HS_BIT];
      de_reg <= linkWord_reg[rpm_pkg::DE_BIT];
    end
  end

  assign pixelOut = pixel_reg;
  assign vertical_sync_out = vsync_reg;
  assign horizontal_sync_out = hsync_reg;
  assign data_enable_out = de_reg;
  // gating may clip one pixel clock pulse at enable or disable
  assign pixelClkOut = outOnLink ?
    linkIf.pixelClk : rpm_pkg::PCLK_IDLE;
  assign pllRun = (state_reg == rpm_pkg::ST_ACQUIRE) ||
    (state_reg == rpm_pkg::ST_ACTIVE);
  assign pllStandby = (state_reg == rpm_pkg::ST_STANDBY);
  assign powerState = state_reg;
endmodule
`default_nettype wire

// File: verif/rpm_link_tx_model.sv
// Purpose: transmitter stand-in driving link clock and words
// Assumes: 30 ns link period, phase free of clk_sys
// Notes: clock stands still while run is low; idle data inverted
`timescale 1ns/1ps
`default_nettype none
module rpm_link_tx_model
(
  input wire logic run,
  input wire logic [rpm_pkg::WORD_W-1:0] word,
  output logic clk_link,
  output logic [rpm_pkg::WORD_W-1:0] linkWordIn,
  output logic linkWordValid
);
  initial
  begin
    clk_link = 1'h0;
    linkWordIn = '0;
    linkWordValid = 1'h0;
    #3.7;
    forever
    begin
      #15;
      if (run)
        clk_link = ~clk_link;
    end
  end
  always @(posedge clk_link)
  begin
    linkWordIn <= word;
    linkWordValid <= run;
  end
  // a stale word must not pass for fresh data
  always @(negedge run)
  begin
    linkWordIn <= ~linkWordIn;
    linkWordValid <= 1'h0;
  end
endmodule
`default_nettype wire

// File: verif/rpm_checker.sv
// Purpose: port checks on the power-mode controller
// Assumes: enable and link clock sampled on clk_sys as data
// Notes: the 11-bit counters saturate so long waits stay cheap
`timescale 1ns/1ps
`default_nettype none
module rpm_checker
#(
  parameter int LOCK_CYCLES = 50
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_link,
  input wire logic receive_enable_in,
  input wire logic clock_polarity_select,
  input wire logic [rpm_pkg::WORD_W-1:0] linkWordIn,
  input wire logic linkWordValid,
  input wire logic [rpm_pkg::PIX_W-1:0] pixelOut,
  input wire logic vertical_sync_out,
  input wire logic horizontal_sync_out,
  input wire logic data_enable_out,
  input wire logic pixelClkOut,
  input wire logic pllRun,
  input wire logic pllStandby,
  input wire logic [1:0] powerState
);
  logic [10:0] hiCnt_reg, loCnt_reg, idleCnt_reg;
  logic [19:0] acqCnt_reg;
  logic linkPrev_reg;
  logic quiet;
  assign quiet = pixelOut == rpm_pkg::PIX_IDLE && vertical_sync_out
    && horizontal_sync_out && !data_enable_out && !pixelClkOut;
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      hiCnt_reg <= 11'h0;
      loCnt_reg <= 11'h0;
      idleCnt_reg <= 11'h0;
      acqCnt_reg <= 20'h0;
      linkPrev_reg <= 1'h0;
    end
    else
    begin
      hiCnt_reg <= receive_enable_in ? hiCnt_reg + 11'(~&hiCnt_reg) : 11'h0;
      loCnt_reg <= receive_enable_in ? 11'h0 : loCnt_reg + 11'(~&loCnt_reg);
      idleCnt_reg <= (clk_link != linkPrev_reg) ? 11'h0
        : idleCnt_reg + 11'(~&idleCnt_reg);
      acqCnt_reg <= (powerState == 2'h2) ? acqCnt_reg + 20'h1 : 20'h0;
      linkPrev_reg <= clk_link;
    end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  a_wake_filter: assert property (
    $past(powerState) == 2'h0 && powerState != 2'h0 |-> hiCnt_reg >= 11'h17C)
    else $error("left shutdown on a short enable pulse");
  a_sleep_filter: assert property (
    $past(powerState) != 2'h0 && powerState == 2'h0 |-> loCnt_reg >= 11'h17C)
    else $error("shut down on a short enable drop");
  a_off_bound: assert property (
    loCnt_reg >= 11'h44C |-> powerState == 2'h0 && !pllRun)
    else $error("not shut down 11 us after enable low");
  a_off_static: assert property (
    powerState == 2'h0 [*3] |-> quiet && !pllRun && !pllStandby)
    else $error("outputs not static in shutdown");
  a_stby_bound: assert property (
    idleCnt_reg >= 11'h12C && powerState != 2'h0 |-> powerState == 2'h1)
    else $error("no standby 3 us after link stop");
  a_stby_static: assert property (
    powerState == 2'h1 [*3] |-> quiet && pllStandby && !pllRun)
    else $error("outputs not static in standby");
  a_lock_bound: assert property (
    acqCnt_reg <= 20'(LOCK_CYCLES + 2))
    else $error("lock wait too long");
  a_active_pll: assert property (
    powerState == 2'h3 [*2] |-> pllRun && !pllStandby)
    else $error("pll levels wrong while active");
endmodule
bind rpm_receiver_power_mode_control rpm_checker
  #(.LOCK_CYCLES(LOCK_CYCLES)) rpm_checker_inst (.*);
`default_nettype wire

// File: verif/tb_rpm_receiver_power_mode_control.sv
// Purpose: bench for the receiver power-mode control
// Assumes: lock time shortened to 50 cycles
// Notes: state changes checked against a queue of expected states
`timescale 1ns/1ps
`default_nettype none
module tb_rpm_receiver_power_mode_control;
  localparam logic [27:0] IDLE = {rpm_pkg::PIX_IDLE, 4'hC};
  localparam logic [27:0] ALL = 28'hFFFFFFF;
  logic clk_sys = 1'h0, rst_b = 1'h0, en = 1'h0, pol = 1'h0, run = 1'h1;
  logic clkLink, lv, vs, hs, de, pclk, pRun, pStby;
  logic [26:0] word = 27'h0, lw;
  logic [23:0] pix;
  logic [1:0] st, prevSt = 2'h0;
  logic [1:0] expQ[$];
  int fail_count = 0, checked = 0, n, pcnt = 0;
  always #5 clk_sys = ~clk_sys;
  always @(posedge pclk) pcnt++;
  rpm_link_tx_model rpm_link_tx_model_inst (.run(run), .word(word),
    .clk_link(clkLink), .linkWordIn(lw), .linkWordValid(lv));
  rpm_receiver_power_mode_control #(.LOCK_CYCLES(50))
    rpm_receiver_power_mode_control_inst (.clk_sys(clk_sys),
    .rst_b(rst_b), .clk_link(clkLink), .receive_enable_in(en),
    .clock_polarity_select(pol), .linkWordIn(lw), .linkWordValid(lv),
    .pixelOut(pix), .vertical_sync_out(vs), .horizontal_sync_out(hs),
    .data_enable_out(de), .pixelClkOut(pclk), .pllRun(pRun),
    .pllStandby(pStby), .powerState(st));
  task automatic bad(input string m);
    fail_count++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic cmpState(input logic [1:0] e, input logic [1:0] a);
    checked++;
    if (a !== e)
      bad("wrong state");
  endtask
  task automatic cmpWord(input logic [27:0] e, input logic [27:0] m);
    checked++;
    if (({pix, vs, hs, de, pclk} & m) !== e)
      bad("wrong outputs");
  endtask
  task automatic cmpPll(input logic [1:0] e);
    checked++;
    if ({pRun, pStby} !== e)
      bad("wrong pll levels");
  endtask
  task automatic cmpRange(input int v, input int lo, input int hi);
    checked++;
    if (v < lo || v > hi)
      bad("count out of range");
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic waitSt(input logic [1:0] s, input int lim);
    n = 0;
    while (st !== s && n < lim)
    begin
      tick(1);
      n++;
    end
  endtask
  task automatic glitch(input logic lvl);
    en = lvl;
    tick($urandom_range(360, 100));
    en = ~lvl;
    tick(500);
  endtask
  task automatic results;
    if (expQ.size() != 0)
      bad("state change missing");
    $display("checked %0d failed %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // sampled mid-cycle so the state register has settled
  always @(negedge clk_sys)
    if (rst_b && st !== prevSt)
    begin
      prevSt = st;
      if (expQ.size() == 0)
        bad("unexpected state change");
      else
        cmpState(expQ.pop_front(), st);
    end
  initial
  begin
    #200000;
    bad("timeout");
    results();
  end
  initial
  begin
    void'($urandom(32'h4FA95A78));
    tick(4);
    rst_b = 1'h1;
    tick(10);
    glitch(1'h1);
    expQ = '{2'h2, 2'h3};
    en = 1'h1;
    waitSt(2'h3, 600);
    cmpRange(n, 380, 450);
    word = 27'($urandom);
    pol = 1'($urandom);
    tick(20);
    cmpWord({word, 1'h0}, ALL - 28'h1);
    cmpPll(2'h2);
    repeat (2)
    begin
      pcnt = 0;
      tick(30);
      cmpRange(pcnt, 9, 11);
      cmpWord({27'h0, clkLink ^ pol}, 28'h1);
      pol = ~pol;
      tick(10);
    end
    glitch(1'h0);
    cmpWord({word, 1'h0}, ALL - 28'h1);
    expQ.push_back(2'h1);
    run = 1'h0;
    waitSt(2'h1, 400);
    cmpRange(n, 100, 300);
    tick(2);
    cmpWord(IDLE, ALL);
    cmpPll(2'h1);
    expQ = '{2'h2, 2'h3};
    run = 1'h1;
    waitSt(2'h3, 300);
    cmpRange(n, 50, 200);
    tick(20);
    cmpWord({word, 1'h0}, ALL - 28'h1);
    expQ.push_back(2'h0);
    en = 1'h0;
    waitSt(2'h0, 1100);
    cmpRange(n, 380, 1099);
    tick(2);
    cmpWord(IDLE, ALL);
    cmpPll(2'h0);
    results();
  end
endmodule
`default_nettype wire
